// File: core/cic_pkg.sv
// Register map, field layout and timing constants of the component input controls
package cic_pkg;
  localparam logic [7:0] ADDR_STATUS_ONE   = 8'h1E;
  localparam logic [7:0] ADDR_STATUS_TWO   = 8'h1F;
  localparam logic [7:0] ADDR_AIC_FIVE     = 8'h23;
  localparam logic [7:0] ADDR_GAIN_THREE   = 8'h24;
  localparam logic [7:0] ADDR_GAIN_FOUR    = 8'h25;
  localparam logic [7:0] ADDR_CDLY_SEL     = 8'h29;

  // Analog input control five fields
  localparam int unsigned AIC_OUT_SEL_BIT   = 7;
  localparam int unsigned AIC_PORT_EN_BIT   = 6;
  localparam int unsigned AIC_CLK_SEL_BIT   = 5;
  localparam int unsigned AIC_CLAMP_REF_BIT = 4;
  localparam int unsigned AIC_SRC_SW_BIT    = 2;
  localparam int unsigned AIC_G4_SIGN_BIT   = 1;
  localparam int unsigned AIC_G3_SIGN_BIT   = 0;
  localparam logic [7:0]  AIC_WR_MASK       = 8'hF7;

  // Component delay / pixel switch fields
  localparam int unsigned CDF_SW_EN_BIT   = 7;
  localparam int unsigned CDF_SW_POL_BIT  = 6;
  localparam int unsigned CDF_SW_DLY_HI   = 5;
  localparam int unsigned CDF_SW_DLY_LO   = 4;
  localparam int unsigned CDF_PEAK_BIT    = 3;
  localparam int unsigned CDF_CP_DLY_HI   = 2;
  localparam int unsigned CDF_CP_DLY_LO   = 0;

  // Status byte bit positions
  localparam int unsigned ST_INTERLACE    = 7;
  localparam int unsigned ST_UNLOCKED     = 6;
  localparam int unsigned ST_FIELD_RATE   = 5;
  localparam int unsigned ST_FOUR_LINE    = 3;
  localparam int unsigned ST_ANY_STRIPE   = 2;
  localparam int unsigned ST_COPY_PROT    = 1;
  localparam int unsigned ST_CAPTURE_RDY  = 0;
  localparam int unsigned ST1_HORIZ_UNLK  = 6;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int unsigned PIX_W      = 8;
  localparam int unsigned GAIN_W     = 9;
  localparam int unsigned DLY_AW     = 6;
  localparam int unsigned STAT_N     = 9;

  // Delay taps around a common base, so negative shifts stay causal
  localparam logic [DLY_AW-1:0] TAP_BASE = 6'h14;
  localparam int unsigned PEAK_SHIFT    = 3;
  localparam logic [PIX_W-1:0] PIX_MAX  = 8'hFF;

  typedef enum logic [1:0] {
    CIC_SEL_STATIC,
    CIC_SEL_PIXEL
  } cic_sel_mode_t;

  // Component shift in pixels per delay code: 0,+4,+8,+12,-16,-12,-8,-4
  function automatic logic [DLY_AW-1:0] cic_comp_tap(input logic [2:0] code);
    logic [DLY_AW-1:0] t;
    t = TAP_BASE;
    case (code)
      3'h1:    t = TAP_BASE + 6'h04;
      3'h2:    t = TAP_BASE + 6'h08;
      3'h3:    t = TAP_BASE + 6'h0C;
      3'h4:    t = TAP_BASE - 6'h10;
      3'h5:    t = TAP_BASE - 6'h0C;
      3'h6:    t = TAP_BASE - 6'h08;
      3'h7:    t = TAP_BASE - 6'h04;
      default: t = TAP_BASE;
    endcase
    return t;
  endfunction

  // Switch shift per code relative to component: 0,+1,-2,-1
  function automatic logic [DLY_AW-1:0] cic_sw_tap(input logic [DLY_AW-1:0] comp,
                                                   input logic [1:0] code);
    logic [DLY_AW-1:0] t;
    t = comp;
    case (code)
      2'h1:    t = comp + 6'h01;
      2'h2:    t = comp - 6'h02;
      2'h3:    t = comp - 6'h01;
      default: t = comp;
    endcase
    return t;
  endfunction
endpackage : cic_pkg

// File: core/cic_sync.sv
// Two-flop synchroniser for a group of status levels
module cic_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_r;
    logic sync_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_r <= 1'b0;
        sync_r <= 1'b0;
      end else if (clk_en) begin
        meta_r <= async_in[i];
        sync_r <= meta_r;
      end
    end

    assign sync_out[i] = sync_r;
  end
endmodule // cic_sync

// File: core/cic_delay_line.sv
// Tapped pixel delay memory with registered read data
module cic_delay_line
  import cic_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic [WIDTH-1:0]  din,
  input  wire logic [DLY_AW-1:0] tap,
  output logic      [WIDTH-1:0]  dout
);
  logic [WIDTH-1:0]  mem [2**DLY_AW];
  logic [DLY_AW-1:0] wr_ptr_r;

  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      mem[wr_ptr_r] <= din;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      dout     <= '0;
    end else if (clk_en) begin
      wr_ptr_r <= wr_ptr_r + 6'h01;
      // Tap zero bypasses the memory
      dout     <= (tap == '0) ? din : mem[wr_ptr_r - tap];
    end
  end
endmodule // cic_delay_line

// File: core/cic_regs.sv
// Component input control and status registers with pixel switch path
// Behaviour
// - Status byte two is read only
// - Bit 7 reads 1 for interlaced source
// - Bit 6 reads 0 only when both loops lock
// - Bit 5 reads 0 at 50 Hz, 1 at 60 Hz
// - Four-line stripe flag follows its detector
// - Bit 2 reads 1 for any stripe burst
// - Bit 0 ready only when all loops lock
// - Port enable bit drives converter port enable
// - Clock select picks line-locked or external clock
// - Clamp follows mode bit, or reference mode
// - Enabled indicator edges reset the gain loop
// - Channel three gain is nine-bit sign plus byte
// - Channel four gain is nine-bit sign plus byte
// - Switch enable allows per-pixel source selection
// - Polarity bit inverts per-pixel switch sense
// - Disabled switch keeps composite selected; polarity only drives static_high_modes
// - Switch delay code shifts switch timing
// - Peaking bit boosts component luminance
// - Component delay code shifts component video
// - Status byte one bit 6 shows horizontal unlock
module cic_regs
  import cic_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  // Subaddress port of the serial control bus front end
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_rvalid,
  // Live detector levels
  input  wire logic                interlaced_flag,
  input  wire logic                horiz_unlock_flag,
  input  wire logic                vert_unlock_in,
  input  wire logic                field_rate_flag,
  input  wire logic                four_line_stripe_flag,
  input  wire logic                any_stripe_flag,
  input  wire logic                copy_protect_flag,
  input  wire logic                loops_all_locked_in,
  input  wire logic                clamp_mode_bit,
  input  wire logic                source_switch_indicator_input,
  // Converter control
  output logic                     converter_port_enable,
  output logic                     converter_clock_select,
  output logic                     clamp_reference_select,
  output logic                     clamp_mode_effective,
  output logic                     gain_loop_reset,
  output logic [GAIN_W-1:0]        gain_three,
  output logic [GAIN_W-1:0]        gain_four,
  output logic                     analog_out_select_msb,
  // Video path
  input  wire logic [PIX_W-1:0]    composite_pix,
  input  wire logic [PIX_W-1:0]    component_pix,
  input  wire logic                pixel_switch_input,
  output logic [PIX_W-1:0]         pixel_out,
  output logic                     component_selected,
  output logic                     static_high_modes
);
  logic [7:0]        aic_five_r;
  logic [7:0]        gain_three_lo_r;
  logic [7:0]        gain_four_lo_r;
  logic [7:0]        cdf_r;
  logic [STAT_N-1:0] stat_sync;
  logic [7:0]        status_two;
  logic [7:0]        status_one;
  logic [7:0]        rd_mux;
  logic              indicator_d_r;
  logic [DLY_AW-1:0] comp_tap;
  logic [DLY_AW-1:0] sw_tap;
  logic [PIX_W-1:0]  comp_dly;
  logic [PIX_W-1:0]  cvbs_dly;
  logic              sw_dly;
  logic [PIX_W-1:0]  comp_prev_r;
  logic [PIX_W:0]    peak_sum;
  logic [PIX_W-1:0]  comp_peaked;
  logic              sel_comp;
  cic_sel_mode_t     sel_mode;

  // Detector levels into the register domain
  cic_sync #(
    .WIDTH (STAT_N)
  ) u_status_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in ({source_switch_indicator_input, interlaced_flag, horiz_unlock_flag,
                vert_unlock_in, field_rate_flag, four_line_stripe_flag,
                any_stripe_flag, copy_protect_flag, loops_all_locked_in}),
    .sync_out (stat_sync)
  );

  // Status bytes assembled from synchronised levels
  always_comb begin
    status_two = RESET_BYTE;
    status_two[ST_INTERLACE]   = stat_sync[7];
    status_two[ST_UNLOCKED]    = stat_sync[6] | stat_sync[5];
    status_two[ST_FIELD_RATE]  = stat_sync[4];
    status_two[ST_FOUR_LINE]   = stat_sync[3];
    status_two[ST_ANY_STRIPE]  = stat_sync[2];
    status_two[ST_COPY_PROT]   = stat_sync[1];
    status_two[ST_CAPTURE_RDY] = stat_sync[0] & ~stat_sync[6] & ~stat_sync[5];
    status_one = RESET_BYTE;
    status_one[ST1_HORIZ_UNLK] = stat_sync[6];
  end

  // Register writes; status addresses have no storage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aic_five_r      <= RESET_BYTE;
      gain_three_lo_r <= RESET_BYTE;
      gain_four_lo_r  <= RESET_BYTE;
      cdf_r           <= RESET_BYTE;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        ADDR_AIC_FIVE:   aic_five_r      <= reg_wdata & AIC_WR_MASK;
        ADDR_GAIN_THREE: gain_three_lo_r <= reg_wdata;
        ADDR_GAIN_FOUR:  gain_four_lo_r  <= reg_wdata;
        ADDR_CDLY_SEL:   cdf_r           <= reg_wdata;
        default:         ;
      endcase
    end
  end

  always_comb begin
    case (reg_addr)
      ADDR_STATUS_ONE: rd_mux = status_one;
      ADDR_STATUS_TWO: rd_mux = status_two;
      ADDR_AIC_FIVE:   rd_mux = aic_five_r;
      ADDR_GAIN_THREE: rd_mux = gain_three_lo_r;
      ADDR_GAIN_FOUR:  rd_mux = gain_four_lo_r;
      ADDR_CDLY_SEL:   rd_mux = cdf_r;
      default:         rd_mux = RESET_BYTE;
    endcase
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= RESET_BYTE;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // Converter controls
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_port_enable  <= 1'b0;
      converter_clock_select <= 1'b0;
      clamp_reference_select <= 1'b0;
      clamp_mode_effective   <= 1'b0;
      analog_out_select_msb  <= 1'b0;
      gain_three             <= '0;
      gain_four              <= '0;
    end else if (clk_en) begin
      converter_port_enable  <= aic_five_r[AIC_PORT_EN_BIT];
      converter_clock_select <= aic_five_r[AIC_CLK_SEL_BIT];
      clamp_reference_select <= aic_five_r[AIC_CLAMP_REF_BIT];
      clamp_mode_effective   <= aic_five_r[AIC_CLAMP_REF_BIT] ? 1'b0 : clamp_mode_bit;
      analog_out_select_msb  <= aic_five_r[AIC_OUT_SEL_BIT];
      gain_three <= {aic_five_r[AIC_G3_SIGN_BIT], gain_three_lo_r};
      gain_four  <= {aic_five_r[AIC_G4_SIGN_BIT], gain_four_lo_r};
    end
  end

  // Any slope on the indicator resets the gain loop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      indicator_d_r   <= 1'b0;
      gain_loop_reset <= 1'b0;
    end else if (clk_en) begin
      indicator_d_r   <= stat_sync[8];
      gain_loop_reset <= aic_five_r[AIC_SRC_SW_BIT] & (stat_sync[8] ^ indicator_d_r);
    end
  end

  // Video alignment taps
  assign comp_tap = cic_comp_tap(cdf_r[CDF_CP_DLY_HI:CDF_CP_DLY_LO]);
  assign sw_tap   = cic_sw_tap(comp_tap, cdf_r[CDF_SW_DLY_HI:CDF_SW_DLY_LO]);

  cic_delay_line #(
    .WIDTH (PIX_W)
  ) u_comp_dly (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .din     (component_pix),
    .tap     (comp_tap),
    .dout    (comp_dly)
  );

  cic_delay_line #(
    .WIDTH (PIX_W)
  ) u_cvbs_dly (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .din     (composite_pix),
    .tap     (TAP_BASE),
    .dout    (cvbs_dly)
  );

  cic_delay_line #(
    .WIDTH (1)
  ) u_sw_dly (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .din     (pixel_switch_input),
    .tap     (sw_tap),
    .dout    (sw_dly)
  );

  // Simple high-frequency lift on component luminance
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      comp_prev_r <= '0;
    end else if (clk_en) begin
      comp_prev_r <= comp_dly;
    end
  end

  always_comb begin
    peak_sum = {1'b0, comp_dly};
    if (comp_dly > comp_prev_r) begin
      peak_sum = {1'b0, comp_dly} + {1'b0, (comp_dly - comp_prev_r) >> PEAK_SHIFT};
    end
    comp_peaked = comp_dly;
    if (cdf_r[CDF_PEAK_BIT]) begin
      comp_peaked = peak_sum[PIX_W] ? PIX_MAX : peak_sum[PIX_W-1:0];
    end
  end

  // Source selection per pixel or static
  always_comb begin
    sel_mode = cdf_r[CDF_SW_EN_BIT] ? CIC_SEL_PIXEL : CIC_SEL_STATIC;
    case (sel_mode)
      CIC_SEL_PIXEL:  sel_comp = sw_dly ^ cdf_r[CDF_SW_POL_BIT];
      CIC_SEL_STATIC: sel_comp = 1'b0;
      default:        sel_comp = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pixel_out          <= '0;
      component_selected <= 1'b0;
      static_high_modes  <= 1'b0;
    end else if (clk_en) begin
      pixel_out          <= sel_comp ? comp_peaked : cvbs_dly;
      component_selected <= sel_comp;
      static_high_modes  <= ~cdf_r[CDF_SW_EN_BIT] & cdf_r[CDF_SW_POL_BIT];
    end
  end

  // Checks
  chk_status_readonly: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && reg_wr && reg_addr == ADDR_STATUS_TWO) |=> $stable(aic_five_r) && $stable(cdf_r))
    else $error("status write altered control state");
  chk_interlace_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && reg_rd && reg_addr == ADDR_STATUS_TWO)
      |=> reg_rvalid && reg_rdata[ST_INTERLACE] == $past(stat_sync[7]))
    else $error("interlace bit mismatch");
  chk_lock_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    status_two[ST_UNLOCKED] == (stat_sync[6] || stat_sync[5]))
    else $error("loop lock flag wrong");
  chk_capture_ready: assert property (@(posedge ref_clk) disable iff (!rst_n)
    status_two[ST_CAPTURE_RDY] |-> !status_two[ST_UNLOCKED])
    else $error("capture ready while unlocked");
  chk_sync_latency: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en [*3]) |-> stat_sync[4] == $past(field_rate_flag, 2))
    else $error("field rate not synchronised in two cycles");
  chk_clamp_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && aic_five_r[AIC_CLAMP_REF_BIT]) |=> !clamp_mode_effective)
    else $error("clamp mode passed in reference mode");
  chk_gain_reset_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && !aic_five_r[AIC_SRC_SW_BIT]) |=> !gain_loop_reset)
    else $error("gain reset while indicator disabled");
  chk_gain_three: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && reg_wr && reg_addr == ADDR_GAIN_THREE) ##1 clk_en
      |=> gain_three[PIX_W-1:0] == $past(reg_wdata, 2))
    else $error("gain three low byte not applied");
  chk_port_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en |=> converter_port_enable == $past(aic_five_r[AIC_PORT_EN_BIT]))
    else $error("port enable not following control");
  chk_pixel_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && cdf_r[CDF_SW_EN_BIT]) |=> component_selected == $past(sw_dly ^ cdf_r[CDF_SW_POL_BIT]))
    else $error("pixel switch polarity wrong");

  // Status bytes against live detector levels
  chk_interlace_live: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en [*3]) |-> status_two[ST_INTERLACE] == $past(interlaced_flag, 2))
    else $error("interlace flag not following detector");
  chk_unlock_live: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en [*3]) |-> status_two[ST_UNLOCKED] ==
      ($past(horiz_unlock_flag, 2) || $past(vert_unlock_in, 2)))
    else $error("unlock flag not following detectors");
  chk_field_live: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en [*3]) |-> status_two[ST_FIELD_RATE] == $past(field_rate_flag, 2))
    else $error("field rate flag not following detector");
  chk_four_line_live: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en [*3]) |-> status_two[ST_FOUR_LINE] == $past(four_line_stripe_flag, 2))
    else $error("four-line stripe flag not following detector");
  chk_stripe_live: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en [*3]) |-> status_two[ST_ANY_STRIPE] == $past(any_stripe_flag, 2))
    else $error("stripe flag not following detector");
  chk_ready_live: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en [*3]) |-> status_two[ST_CAPTURE_RDY] == ($past(loops_all_locked_in, 2) &&
      !$past(horiz_unlock_flag, 2) && !$past(vert_unlock_in, 2)))
    else $error("capture ready not following lock detectors");
  chk_horiz_live: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en [*3]) |-> status_one[ST1_HORIZ_UNLK] == $past(horiz_unlock_flag, 2))
    else $error("horizontal unlock flag not following detector");

  // Register fields reaching their outputs
  chk_clock_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en |=> converter_clock_select == $past(aic_five_r[AIC_CLK_SEL_BIT]))
    else $error("clock select not following control");
  chk_clamp_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && !aic_five_r[AIC_CLAMP_REF_BIT])
      |=> clamp_mode_effective == $past(clamp_mode_bit))
    else $error("clamp mode not followed outside reference mode");
  chk_gain_four: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en |=> gain_four == {$past(aic_five_r[AIC_G4_SIGN_BIT]), $past(gain_four_lo_r)})
    else $error("gain four not sign bit over low byte");
  chk_gain_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && aic_five_r[AIC_SRC_SW_BIT] && $changed(stat_sync[8])) |=> gain_loop_reset)
    else $error("indicator edge did not reset gain loop");
  chk_static_pixel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && !cdf_r[CDF_SW_EN_BIT])
      |=> !component_selected && static_high_modes == $past(cdf_r[CDF_SW_POL_BIT]))
    else $error("static selection wrong with switch disabled");
endmodule // cic_regs

// File: verif/cic_host_model.sv
// Host model driving the subaddress register port
module cic_host_model (
  input  wire logic       ref_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Released lines change pattern instead of keeping the last value
  task automatic idle();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    idle();
  endtask

  // Answer pulse rises on the taking edge itself and is sampled just after it
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    d = reg_rdata;
    v = reg_rvalid;
    idle();
  endtask
endmodule // cic_host_model

// File: verif/tb_component_input_control_regs.sv
// Self-checking bench for the component input control registers
module tb_component_input_control_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import cic_pkg::*;

  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       clk_en = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pixel_out;
  logic [7:0] det = 8'h00;
  logic [7:0] composite_pix = 8'h00;
  logic [7:0] component_pix = 8'h00;
  logic       reg_wr, reg_rd, reg_rvalid, gain_loop_reset, component_selected;
  logic       converter_port_enable, converter_clock_select, static_high_modes;
  logic       clamp_reference_select, clamp_mode_effective, aout_msb;
  logic       clamp_mode_bit = 1'b0;
  logic       source_switch_indicator_input = 1'b0;
  logic       pixel_switch_input = 1'b0;
  logic [8:0] gain_three, gain_four;
  int         mismatches = 0;
  int         checks = 0;
  int         pulses = 0;
  int         base, n;
  // Rows: detectors, address, write data, expected read back
  logic [31:0] rows [15] = '{
    32'h0023FFF7,
    32'h00249090,
    32'h00255A5A,
    32'h00293B3B,
    32'h801FFF80,
    32'h401FFF40,
    32'h401EFF40,
    32'h201F0040,
    32'h101FFF20,
    32'h081FFF08,
    32'h041FFF04,
    32'h021FFF02,
    32'h011FFF01,
    32'h211FFF40,
    32'h0030AA00};
  // Switch cases: config, switch level, pixel, selected and static flags
  logic [27:0] sw_rows [6] = '{28'h00_0_11_00, 28'h40_1_11_01, 28'h80_1_22_02,
                               28'h80_0_11_00, 28'hC0_1_11_00, 28'hC0_0_22_02};
  int cshift [8] = '{0, 4, 8, 12, -16, -12, -8, -4};
  int sshift [4] = '{0, 1, -2, -1};

  cic_host_model host (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
                       .reg_rvalid);

  cic_regs DUT (
    .ref_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .interlaced_flag(det[7]), .horiz_unlock_flag(det[6]), .vert_unlock_in(det[5]),
    .field_rate_flag(det[4]), .four_line_stripe_flag(det[3]), .any_stripe_flag(det[2]),
    .copy_protect_flag(det[1]), .loops_all_locked_in(det[0]), .clamp_mode_bit,
    .source_switch_indicator_input, .converter_port_enable, .converter_clock_select,
    .clamp_reference_select, .clamp_mode_effective, .gain_loop_reset, .gain_three,
    .gain_four, .analog_out_select_msb(aout_msb), .composite_pix, .component_pix,
    .pixel_switch_input, .pixel_out, .component_selected, .static_high_modes
  );

  always #20 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (gain_loop_reset === 1'b1) begin
      pulses++;
    end
  end

  task automatic chk_val(input string nm, input logic [8:0] exp, input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_cnt(input string nm, input int exp, input int got);
    checks++;
    if (got != exp) begin
      mismatches++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write(a, d);
    settle(2);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.read(a, d, v);
    chk_val("read answer", 9'h001, 9'(v));
    chk_val($sformatf("register %h", a), 9'(exp), 9'(d));
  endtask

  // Cycles from a one-pixel marker to its arrival at the pixel output
  task automatic lat(input logic [7:0] cfg, input logic on_sw, output int k);
    wr(ADDR_CDLY_SEL, cfg);
    component_pix = on_sw ? 8'hAA : 8'h00;
    pixel_switch_input = !on_sw;
    settle(70);
    if (on_sw) pixel_switch_input = 1'b1;
    else component_pix = 8'h55;
    settle(1);
    if (on_sw) pixel_switch_input = 1'b0;
    else component_pix = 8'h00;
    k = 1;
    while (pixel_out !== (on_sw ? 8'hAA : 8'h55) && k < 60) begin
      settle(1);
      k++;
    end
  endtask

  initial begin
    settle(6);
    chk_val("port enable in reset", 9'h000, 9'(converter_port_enable));
    chk_val("gain three in reset", 9'h000, gain_three);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      if (i < 4) rd_chk(rows[i][23:16], 8'h00);
    end
    foreach (rows[i]) begin
      det = rows[i][31:24];
      host.write(rows[i][23:16], rows[i][15:8]);
      settle(3);
      rd_chk(rows[i][23:16], rows[i][7:0]);
    end
    det = 8'h00;
    chk_val("output select", 9'h001, 9'(aout_msb));
    clamp_mode_bit = 1'b1;
    wr(ADDR_AIC_FIVE, 8'h70);
    chk_val("output select off", 9'h000, 9'(aout_msb));
    chk_val("port enable", 9'h001, 9'(converter_port_enable));
    chk_val("clock select", 9'h001, 9'(converter_clock_select));
    chk_val("reference mode", 9'h001, 9'(clamp_reference_select));
    chk_val("clamp mode", 9'h000, 9'(clamp_mode_effective));
    wr(ADDR_AIC_FIVE, 8'h03);
    chk_val("port disabled", 9'h000, 9'(converter_port_enable));
    chk_val("clock internal", 9'h000, 9'(converter_clock_select));
    chk_val("clamp follows", 9'h001, 9'(clamp_mode_effective));
    wr(ADDR_GAIN_THREE, 8'h90);
    wr(ADDR_GAIN_FOUR, 8'hFF);
    chk_val("gain three", 9'h190, gain_three);
    chk_val("gain four 511", 9'h1FF, gain_four);
    wr(ADDR_AIC_FIVE, 8'h04);
    chk_val("gain three 144", 9'h090, gain_three);
    chk_val("gain four", 9'h0FF, gain_four);
    wr(ADDR_GAIN_THREE, 8'h00);
    chk_val("gain three 0", 9'h000, gain_three);
    for (int en = 1; en >= 0; en--) begin
      wr(ADDR_AIC_FIVE, {5'h00, en[0], 2'b00});
      pulses = 0;
      source_switch_indicator_input = 1'b1;
      settle(8);
      source_switch_indicator_input = 1'b0;
      settle(8);
      chk_cnt("gain loop resets", 2 * en, pulses);
    end
    composite_pix = 8'h11;
    component_pix = 8'h22;
    // Synchronous component source assumed before pixel switching is enabled
    foreach (sw_rows[i]) begin
      wr(ADDR_CDLY_SEL, sw_rows[i][27:20]);
      pixel_switch_input = sw_rows[i][16];
      settle(70);
      chk_val("pixel out", 9'(sw_rows[i][15:8]), 9'(pixel_out));
      chk_val("component sel", 9'(sw_rows[i][1]), 9'(component_selected));
      chk_val("static high", 9'(sw_rows[i][0]), 9'(static_high_modes));
    end
    composite_pix = 8'h00;
    // Highest output level after a rising component step
    for (int pk = 0; pk < 2; pk++) begin
      wr(ADDR_CDLY_SEL, {4'h8, pk[0], 3'h0});
      pixel_switch_input = 1'b1;
      component_pix = 8'h00;
      settle(70);
      component_pix = 8'h80;
      n = 0;
      repeat (40) begin
        settle(1);
        if (pixel_out > n) n = pixel_out;
      end
      chk_cnt("peak level", pk ? 8'h90 : 8'h80, n);
    end
    lat(8'h80, 1'b0, base);
    foreach (cshift[i]) begin
      lat({5'b10000, 3'(i)}, 1'b0, n);
      chk_cnt("component shift", base + cshift[i], n);
    end
    lat(8'h80, 1'b1, base);
    foreach (sshift[i]) begin
      lat({2'b10, 2'(i), 4'h0}, 1'b1, n);
      chk_cnt("switch shift", base + sshift[i], n);
    end
    wr(ADDR_GAIN_FOUR, 8'h5A);
    rst_n = 1'b0;
    settle(2);
    chk_val("gain four reset", 9'h000, gain_four);
    rst_n = 1'b1;
    rd_chk(ADDR_GAIN_FOUR, 8'h00);
    give_verdict();
  end

  // Run needs about 2200 cycles
  initial begin
    #(10000 * 40);
    mismatches++;
    $display("[ERR] watchdog expected finish seen hang");
    give_verdict();
  end
endmodule // tb_component_input_control_regs
